// [phsr_jabber_timer.sv]
// phsr_jabber_timer: measures one transmission in 10 Mb/s mode and cuts it off when too long
// assumes tx_active_i and mode_10bt_i come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module phsr_jabber_timer #(
	parameter int unsigned LIMIT = phsr_pkg::JABBER_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic tx_active_i,
	input wire logic mode_10bt_i,
	output logic jabber_pulse_o,
	output logic cutoff_o
);
	typedef struct packed {
		logic [phsr_pkg::JAB_CNT_W-1:0] cnt;
		logic pulse;
		logic cut;
	} phsr_jab_state_type;

	phsr_jab_state_type st_reg;
	phsr_jab_state_type st_next;

	localparam int unsigned CNT_W = phsr_pkg::JAB_CNT_W;
	localparam logic [CNT_W-1:0] LIMIT_W = CNT_W'(LIMIT);

	always_comb begin
		st_next = st_reg;
		st_next.pulse = 1'b0;
		// only 10 Mb/s has a jabber function
		if (!tx_active_i || !mode_10bt_i) begin // [R11]
			st_next.cnt = '0;
			st_next.cut = 1'b0;
		end else if (!st_reg.cut) begin
			if (st_reg.cnt >= LIMIT_W) begin
				st_next.cut = 1'b1; // [R8]
				st_next.pulse = 1'b1; // [R8]
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign jabber_pulse_o = st_reg.pulse;
	assign cutoff_o = st_reg.cut;

	chk_jab_mode_only: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R11]
		jabber_pulse_o |-> $past(mode_10bt_i)) else $error("jabber flagged outside 10 Mb/s mode");
endmodule : phsr_jabber_timer
`default_nettype wire

// [phsr_mgmt_model.sv]
// phsr_mgmt_model: management controller issuing one-cycle register strobes
// assumes the register block samples strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module phsr_mgmt_model (
	input wire logic clock_i,
	input wire logic [15:0] rdata_i,
	output logic rd_en_o,
	output logic wr_en_o,
	output logic [4:0] addr_o,
	output logic [15:0] wdata_o
);
	initial begin
		rd_en_o = 1'b0;
		wr_en_o = 1'b0;
		addr_o = 5'h00;
		wdata_o = 16'h0000;
	end
	task automatic write(input logic [4:0] a, input logic [15:0] v);
		@(posedge clock_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clock_i);
		wr_en_o <= 1'b0;
	endtask : write
	// the answer is registered, so it is taken at the next edge, where it stands with no read pending
	task automatic read(input logic [4:0] a, output logic [15:0] v);
		@(posedge clock_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clock_i);
		rd_en_o <= 1'b0;
		@(posedge clock_i);
		v = rdata_i;
	endtask : read
endmodule : phsr_mgmt_model
`default_nettype wire

// [phsr_pkg.sv]
// phsr_pkg: shared constants for the phy status and identifier register block
// assumes a 200 MHz management clock and 5-bit register addressing
package phsr_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;
	localparam logic [4:0] STATUS_ADDR = 5'h01;
	localparam logic [4:0] ID_HIGH_ADDR = 5'h02;
	// status field positions
	localparam int unsigned EXT_CAP_BIT = 0;
	localparam int unsigned JABBER_BIT = 1;
	localparam int unsigned LINK_BIT = 2;
	localparam int unsigned AN_ABILITY_BIT = 3;
	localparam int unsigned REMOTE_FAULT_BIT = 4;
	localparam int unsigned AN_DONE_BIT = 5;
	localparam int unsigned PREAMBLE_SKIP_BIT = 6;
	// identifier reset value is arbitrary, not a real vendor code
	localparam logic [15:0] ID_HIGH_RESET = 16'h0a5c;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// jabber limit: transmission longer than this is cut
	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned JABBER_TIME_MS = 105;
	localparam int unsigned JABBER_CYCLES = JABBER_TIME_MS * CLK_KHZ;
	localparam int unsigned JAB_CNT_W = 25;
endpackage : phsr_pkg

// [phsr_regs.sv]
// phsr_regs: basic status register (low half) and first identifier register of the phy
// assumes a management frame engine on the same clock issues one-cycle read and write strobes
// Functional notes
// [R1] status bit 6 copies the management preamble configuration bit.
// [R2] status bit 5 reads 1 once auto-negotiation has completed, 0 after reset.
// [R3] with auto-negotiation on, bit 4 follows the link partner remote fault bit.
// [R4] with auto-negotiation off, bit 4 follows the far end fault detector.
// [R5] status bit 3 always reads 1.
// [R6] status bit 2 reports a valid link and resets to 0.
// [R7] a link failure clears bit 2 and keeps it clear until the status register is read.
// [R8] in 10 Mb/s mode a transmission over 105 ms is cut off and sets the jabber bit.
// [R9] a set jabber bit with its mask bit set raises the management interrupt.
// [R10] the jabber bit stays set until a status read, an interrupt status read or reset.
// [R11] no jabber is flagged in 100 Mb/s mode.
// [R12] status bit 0 always reads 1.
// [R13] the identifier register holds vendor id bits 3 to 18, bit 3 in register bit 15.
// [R14] writes to the identifier register are ignored while legacy mode is set.
// [R15] a clearing status read returns the latched value and the flag reloads next cycle.
`timescale 1ns/1ps
`default_nettype none
module phsr_regs #(
	parameter int unsigned JABBER_LIMIT = phsr_pkg::JABBER_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic rd_en_i,
	input wire logic wr_en_i,
	input wire logic [phsr_pkg::ADDR_W-1:0] addr_i,
	input wire logic [phsr_pkg::DATA_W-1:0] wdata_i,
	output logic [phsr_pkg::DATA_W-1:0] rdata_o,
	input wire logic link_ok_i,
	input wire logic an_enable_i,
	input wire logic an_complete_i,
	input wire logic lp_remote_fault_i,
	input wire logic far_end_fault_i,
	input wire logic mode_10bt_i,
	input wire logic tx_active_i,
	input wire logic mgmt_preamble_required_cfg_i,
	input wire logic legacy_compat_i,
	input wire logic jabber_irq_mask_i,
	input wire logic isr_read_i,
	output logic tx_cutoff_o,
	output logic mgmt_irq_o
);
	typedef struct packed {
		logic link_lat;
		logic jab_lat;
		logic [15:0] vendor_unique_id;
		logic [15:0] rdata;
		logic irq;
	} phsr_state_type;

	phsr_state_type st_reg;
	phsr_state_type st_next;
	logic rst_meta_reg;
	logic rst_n_reg;
	logic jab_pulse;
	logic status_rd;
	logic id_wr;
	logic id_rd;

	// async assert, synchronous release
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	phsr_jabber_timer #(
		.LIMIT(JABBER_LIMIT)
	) u_jab (
		.clock_i(clock_i),
		.rst_n_i(rst_n_reg),
		.tx_active_i(tx_active_i),
		.mode_10bt_i(mode_10bt_i),
		.jabber_pulse_o(jab_pulse),
		.cutoff_o(tx_cutoff_o)
	);

	function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] target);
		addr_hit = (a == target);
	endfunction : addr_hit

	assign status_rd = rd_en_i && addr_hit(addr_i, phsr_pkg::STATUS_ADDR);
	assign id_wr = wr_en_i && addr_hit(addr_i, phsr_pkg::ID_HIGH_ADDR);
	assign id_rd = rd_en_i && addr_hit(addr_i, phsr_pkg::ID_HIGH_ADDR);

	always_comb begin
		st_next = st_reg;
		// link latches low; a read reloads from the live link
		if (status_rd) begin
			st_next.link_lat = link_ok_i; // [R15]
		end else begin
			st_next.link_lat = st_reg.link_lat & link_ok_i; // [R7]
		end
		// a new jabber in the clearing cycle wins over the clear
		if (status_rd || isr_read_i) begin
			st_next.jab_lat = jab_pulse; // [R10]
		end else begin
			st_next.jab_lat = st_reg.jab_lat | jab_pulse; // [R10]
		end
		if (id_wr && !legacy_compat_i) begin
			st_next.vendor_unique_id = wdata_i; // [R14]
		end
		st_next.irq = st_reg.jab_lat & jabber_irq_mask_i; // [R9]
		if (rd_en_i) begin
			st_next.rdata = '0;
			if (status_rd) begin
				st_next.rdata[phsr_pkg::EXT_CAP_BIT] = 1'b1; // [R12]
				st_next.rdata[phsr_pkg::JABBER_BIT] = st_reg.jab_lat; // [R15]
				st_next.rdata[phsr_pkg::LINK_BIT] = st_reg.link_lat; // [R6]
				st_next.rdata[phsr_pkg::AN_ABILITY_BIT] = 1'b1; // [R5]
				st_next.rdata[phsr_pkg::REMOTE_FAULT_BIT] = an_enable_i ? lp_remote_fault_i : far_end_fault_i; // [R3] [R4]
				st_next.rdata[phsr_pkg::AN_DONE_BIT] = an_complete_i; // [R2]
				st_next.rdata[phsr_pkg::PREAMBLE_SKIP_BIT] = mgmt_preamble_required_cfg_i; // [R1]
			end else if (addr_hit(addr_i, phsr_pkg::ID_HIGH_ADDR)) begin
				// id bit 3 sits in register bit 15
				st_next.rdata = st_reg.vendor_unique_id; // [R13]
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			st_reg.link_lat <= 1'b0;
			st_reg.jab_lat <= 1'b0;
			st_reg.vendor_unique_id <= phsr_pkg::ID_HIGH_RESET;
			st_reg.rdata <= phsr_pkg::STATUS_RESET;
			st_reg.irq <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;
	assign mgmt_irq_o = st_reg.irq;

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_reg);

	// link flag
	chk_link_fail_latch: assert property ( // [R7]
		!link_ok_i |=> !st_reg.link_lat)
		else $error("link flag not cleared");
	chk_link_hold_low: assert property ( // [R7]
		!st_reg.link_lat && !status_rd ##1 !status_rd |-> !st_reg.link_lat)
		else $error("link flag recovered without read");
	chk_link_reload: assert property ( // [R15]
		status_rd |=> st_reg.link_lat == $past(link_ok_i))
		else $error("link flag did not reload after read");

	// jabber flag and interrupt
	chk_jab_sticky: assert property ( // [R10]
		st_reg.jab_lat && !status_rd && !isr_read_i |=> st_reg.jab_lat)
		else $error("jabber flag dropped without clear");
	chk_jab_clear: assert property ( // [R10]
		(status_rd || isr_read_i) && !jab_pulse |=> !st_reg.jab_lat)
		else $error("jabber flag survived its clear");
	chk_irq_follow: assert property ( // [R9]
		st_reg.jab_lat && jabber_irq_mask_i |=> mgmt_irq_o)
		else $error("interrupt missing on masked jabber");
	chk_irq_quiet: assert property ( // [R9]
		!(st_reg.jab_lat && jabber_irq_mask_i) |=> !mgmt_irq_o)
		else $error("interrupt without masked jabber");

	// status read word
	chk_status_fixed: assert property ( // [R5] [R12]
		status_rd |=> rdata_o[0] && rdata_o[3])
		else $error("constant ones wrong");
	chk_upper_zero: assert property (
		status_rd |=> rdata_o[15:7] == 9'h000)
		else $error("unused status bits not zero");
	chk_read_latched: assert property ( // [R15]
		status_rd |=> rdata_o[2] == $past(st_reg.link_lat) && rdata_o[1] == $past(st_reg.jab_lat))
		else $error("read did not return latched flags");
	chk_rfault_sel: assert property ( // [R3] [R4]
		status_rd |=> rdata_o[4] == ($past(an_enable_i) ? $past(lp_remote_fault_i) : $past(far_end_fault_i)))
		else $error("remote fault source wrong");
	chk_preamble_copy: assert property ( // [R1] [R2]
		status_rd |=> rdata_o[6] == $past(mgmt_preamble_required_cfg_i) && rdata_o[5] == $past(an_complete_i))
		else $error("preamble or an done bit wrong");

	// identifier register and read port
	chk_id_lock: assert property ( // [R14]
		id_wr && legacy_compat_i |=> $stable(st_reg.vendor_unique_id))
		else $error("id written in legacy mode");
	chk_id_write: assert property ( // [R14]
		id_wr && !legacy_compat_i |=> st_reg.vendor_unique_id == $past(wdata_i))
		else $error("id write lost outside legacy mode");
	chk_id_read: assert property ( // [R13]
		id_rd |=> rdata_o == $past(st_reg.vendor_unique_id))
		else $error("id read returned wrong word");
	chk_unmapped_zero: assert property (
		rd_en_i && !status_rd && !id_rd |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	// read data must stand for the controller until the next read
	chk_rdata_hold: assert property (
		!rd_en_i |=> $stable(rdata_o))
		else $error("read data changed without a read");

	// jabber timer seen from here
	chk_no_jab_100: assert property ( // [R11]
		!mode_10bt_i |=> !jab_pulse && !tx_cutoff_o)
		else $error("jabber seen in 100 Mb/s mode");
	chk_cut_release: assert property ( // [R8]
		!tx_active_i |=> !tx_cutoff_o)
		else $error("cutoff held after transmission ended");
	chk_jab_cutoff: assert property ( // [R8]
		$rose(jab_pulse) |-> tx_cutoff_o ##1 st_reg.jab_lat)
		else $error("jabber not latched");

	// main scenarios
	cov_link_read: cover property (!st_reg.link_lat && link_ok_i && status_rd ##1 st_reg.link_lat);
	cov_jab_irq: cover property (jab_pulse ##[1:3] mgmt_irq_o);
	cov_id_write: cover property (id_wr && !legacy_compat_i);
	cov_isr_clear: cover property (st_reg.jab_lat && isr_read_i ##1 !st_reg.jab_lat);
	cov_far_fault: cover property (status_rd && !an_enable_i && far_end_fault_i);
endmodule : phsr_regs
`default_nettype wire

// [testbench.sv]
// testbench: register reads, writes and status events for phsr_regs
// assumes a short jabber limit so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned LIM = 20;
	logic clock_i, resetn_i, rd_en, wr_en, link_ok, an_en, an_cmp, lp_rf, fe_f;
	logic m10, tx, pre_cfg, legacy, jmask, isr_rd, cutoff, irq;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, d;
	int n_mismatch = 0;
	int n_checks = 0;
	phsr_regs #(.JABBER_LIMIT(LIM)) phsr_regs_inst (.clock_i(clock_i), .resetn_i(resetn_i),
		.rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
		.link_ok_i(link_ok), .an_enable_i(an_en), .an_complete_i(an_cmp), .lp_remote_fault_i(lp_rf),
		.far_end_fault_i(fe_f), .mode_10bt_i(m10), .tx_active_i(tx), .mgmt_preamble_required_cfg_i(pre_cfg),
		.legacy_compat_i(legacy), .jabber_irq_mask_i(jmask), .isr_read_i(isr_rd),
		.tx_cutoff_o(cutoff), .mgmt_irq_o(irq));
	phsr_mgmt_model phsr_mgmt_model_inst (.clock_i(clock_i), .rdata_i(rdata), .rd_en_o(rd_en),
		.wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		phsr_mgmt_model_inst.read(a, d);
		chk("rdata", exp, d);
	endtask : rd_chk
	task automatic pins_chk(input logic c, input logic i);
		chk("cutoff", {15'h0000, c}, {15'h0000, cutoff});
		chk("irq", {15'h0000, i}, {15'h0000, irq});
	endtask : pins_chk
	task automatic burst(input int n);
		@(posedge clock_i);
		tx <= 1'b1;
		repeat (n) @(posedge clock_i);
	endtask : burst
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		{resetn_i, link_ok, an_en, an_cmp, lp_rf, fe_f, m10, tx, pre_cfg, legacy, jmask, isr_rd} = 12'h000;
		repeat (8) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd_chk(5'h01, 16'h0009);
		rd_chk(5'h02, phsr_pkg::ID_HIGH_RESET);
		rd_chk(5'h1f, 16'h0000);
		phsr_mgmt_model_inst.write(5'h02, 16'h1234);
		rd_chk(5'h02, 16'h1234);
		legacy <= 1'b1;
		phsr_mgmt_model_inst.write(5'h02, 16'h5678);
		rd_chk(5'h02, 16'h1234);
		legacy <= 1'b0;
		phsr_mgmt_model_inst.write(5'h01, 16'hffff);
		{link_ok, an_en, an_cmp, lp_rf, pre_cfg} <= 5'h1f;
		rd_chk(5'h01, 16'h0079);
		rd_chk(5'h01, 16'h007d);
		link_ok <= 1'b0;
		@(posedge clock_i);
		link_ok <= 1'b1;
		rd_chk(5'h01, 16'h0079);
		rd_chk(5'h01, 16'h007d);
		an_en <= 1'b0;
		rd_chk(5'h01, 16'h006d);
		fe_f <= 1'b1;
		rd_chk(5'h01, 16'h007d);
		m10 <= 1'b1;
		jmask <= 1'b1;
		burst(LIM + 6);
		pins_chk(1'b1, 1'b1);
		tx <= 1'b0;
		rd_chk(5'h01, 16'h007f);
		rd_chk(5'h01, 16'h007d);
		pins_chk(1'b0, 1'b0);
		jmask <= 1'b0;
		burst(LIM + 6);
		pins_chk(1'b1, 1'b0);
		tx <= 1'b0;
		isr_rd <= 1'b1;
		@(posedge clock_i);
		isr_rd <= 1'b0;
		rd_chk(5'h01, 16'h007d);
		m10 <= 1'b0;
		burst(LIM + 6);
		pins_chk(1'b0, 1'b0);
		rd_chk(5'h01, 16'h007d);
		tx <= 1'b0;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
